// ===== src/pms_pkg.sv
// package for the power-up mode selector: modes, states, carriers, constants
// ============================================================
// Summary of operation
// RULE1: selection runs at power-on and every reset
// RULE2: valid stored configuration starts normal operation directly
// RULE3: first byte 0xFF enters configuration download
// RULE4: any other first byte enters direct test
// RULE5: download fills RAM, repeatable, never committed
// RULE6: reset discards RAM configuration, reselects mode
// RULE7: stored configuration keeps the serial port disabled
// RULE8: stored configuration forbids direct test mode
// RULE9: serial pins carry test and download traffic
// RULE10: test and download modes hold power management off
// RULE11: only first byte decides; later bytes forwarded
package pms_pkg;

    // ============================================================
    // constants
    localparam logic [7:0] PMS_CFG_REQ_BYTE = 8'hff;
    localparam int PMS_RAM_AW = 6;
    localparam int PMS_RAM_DEPTH = 64;
    localparam logic [PMS_RAM_AW-1:0] PMS_RAM_ADDR_RST = 6'h00;
    localparam logic [7:0] PMS_BYTE_RST = 8'h00;
    // cycles to wait for the stored-config check to settle after reset
    localparam logic [1:0] PMS_CHECK_CYCLES = 2'h2;
    localparam logic [1:0] PMS_CNT_RST = 2'h0;

    // ============================================================
    // mode selector states, gray coded along the check, wait, download path
    typedef enum logic [2:0] {
        PMS_ST_CHECK = 3'b000,
        PMS_ST_WAIT = 3'b001,
        PMS_ST_CFG = 3'b011,
        PMS_ST_DTM = 3'b010,
        PMS_ST_NORMAL = 3'b110
    } pms_state_t;

    typedef enum logic [1:0] {
        PMS_MODE_NONE = 2'b00,
        PMS_MODE_NORMAL = 2'b01,
        PMS_MODE_CFG = 2'b10,
        PMS_MODE_DTM = 2'b11
    } pms_mode_t;

    // ============================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pms_byte_t;

    typedef struct packed {
        logic write;
        logic [PMS_RAM_AW-1:0] addr;
        logic [7:0] data;
    } pms_ram_wr_t;

endpackage : pms_pkg

// ===== src/pms_cfg_ram.sv
// configuration RAM held in flip-flops, cleared on every reset
`timescale 1ns/1ps
`default_nettype none
module pms_cfg_ram (
    input wire logic clk,
    input wire logic nrst,
    input wire pms_pkg::pms_ram_wr_t wr,
    input wire logic [pms_pkg::PMS_RAM_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem_r [pms_pkg::PMS_RAM_DEPTH];

    // ============================================================
    // storage
    // RULE6: reset wipes downloaded settings
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < pms_pkg::PMS_RAM_DEPTH; i++) begin
                mem_r[i] <= pms_pkg::PMS_BYTE_RST;
            end
        end else if (wr.write) begin
            mem_r[wr.addr] <= wr.data;
        end
    end

    // registered read port keeps data outputs on flip-flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_data <= pms_pkg::PMS_BYTE_RST;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end

endmodule : pms_cfg_ram
`default_nettype wire

// ===== src/pms_mode_select.sv
// power-up mode selector: stored-config check, first-byte decision, routing
`timescale 1ns/1ps
`default_nettype none
module pms_mode_select (
    input wire logic clk,
    input wire logic nrst,
    // stored configuration status from non-volatile memory
    input wire logic otp_valid,
    // received serial bytes from the UART receiver
    input wire pms_pkg::pms_byte_t uart_rx,
    // bytes to transmit, from the direct test handler
    input wire pms_pkg::pms_byte_t dtm_tx,
    // RAM read port for the configured application
    input wire logic [pms_pkg::PMS_RAM_AW-1:0] cfg_rd_addr,
    output logic [7:0] cfg_rd_data,
    // routed traffic
    output pms_pkg::pms_byte_t dtm_rx,
    output pms_pkg::pms_byte_t uart_tx,
    // status
    output pms_pkg::pms_mode_t mode,
    output logic load_otp,
    output logic uart_enable,
    output logic pwr_mgmt_enable,
    output logic cfg_loaded,
    output logic [pms_pkg::PMS_RAM_AW-1:0] cfg_count
);

    pms_pkg::pms_state_t state_r;
    pms_pkg::pms_state_t state_nxt;
    logic [1:0] check_cnt_r;
    pms_pkg::pms_ram_wr_t ram_wr_r;
    logic [pms_pkg::PMS_RAM_AW-1:0] wr_addr_r;
    logic cfg_loaded_r;
    logic rx_ok;

    // serial receive is only honoured while the port is enabled
    assign rx_ok = uart_rx.valid && uart_enable;

    // ============================================================
    // decoding helpers
    // mode shown for a selector state; check and wait show none
    // kept apart so state codes can change without touching the mode
    function automatic pms_pkg::pms_mode_t mode_of(
        input pms_pkg::pms_state_t st
    );
        pms_pkg::pms_mode_t m;
        case (st)
            pms_pkg::PMS_ST_NORMAL: m = pms_pkg::PMS_MODE_NORMAL;
            pms_pkg::PMS_ST_CFG: m = pms_pkg::PMS_MODE_CFG;
            pms_pkg::PMS_ST_DTM: m = pms_pkg::PMS_MODE_DTM;
            default: m = pms_pkg::PMS_MODE_NONE;
        endcase
        return m;
    endfunction : mode_of

    // states in which the serial pins belong to the host tool
    // the check state is left out so the port opens only once decided
    function automatic logic port_open(input pms_pkg::pms_state_t st);
        return st == pms_pkg::PMS_ST_WAIT ||
               st == pms_pkg::PMS_ST_CFG ||
               st == pms_pkg::PMS_ST_DTM;
    endfunction : port_open

    // only the test state may route bytes to or from the test handler
    function automatic logic test_path(input pms_pkg::pms_state_t st);
        return st == pms_pkg::PMS_ST_DTM;
    endfunction : test_path

    // ============================================================
    // state machine
    // RULE1: every reset restarts selection at the check
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= pms_pkg::PMS_ST_CHECK;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pms_pkg::PMS_ST_CHECK: begin
                if (check_cnt_r == pms_pkg::PMS_CHECK_CYCLES) begin
                    // RULE2: valid stored settings go straight to normal
                    if (otp_valid) begin
                        state_nxt = pms_pkg::PMS_ST_NORMAL;
                    end else begin
                        state_nxt = pms_pkg::PMS_ST_WAIT;
                    end
                end
            end
            pms_pkg::PMS_ST_WAIT: begin
                // RULE11: decision made on the first byte only
                if (rx_ok) begin
                    // RULE3: request byte selects download
                    if (uart_rx.data == pms_pkg::PMS_CFG_REQ_BYTE) begin
                        state_nxt = pms_pkg::PMS_ST_CFG;
                    end else begin
                        // RULE4: anything else selects test mode
                        state_nxt = pms_pkg::PMS_ST_DTM;
                    end
                end
            end
            // chosen modes are held until the next reset
            pms_pkg::PMS_ST_CFG: state_nxt = pms_pkg::PMS_ST_CFG;
            pms_pkg::PMS_ST_DTM: state_nxt = pms_pkg::PMS_ST_DTM;
            pms_pkg::PMS_ST_NORMAL: state_nxt = pms_pkg::PMS_ST_NORMAL;
            default: state_nxt = pms_pkg::PMS_ST_CHECK;
        endcase
    end

    // settle counter: the stored-config flag is sampled after release
    always_ff @(posedge clk) begin
        if (!nrst) begin
            check_cnt_r <= pms_pkg::PMS_CNT_RST;
        end else if (state_r == pms_pkg::PMS_ST_CHECK &&
                     check_cnt_r != pms_pkg::PMS_CHECK_CYCLES) begin
            check_cnt_r <= check_cnt_r + 2'h1;
        end
    end

    // ============================================================
    // configuration download into RAM
    // RULE5: later bytes land in RAM, overwritable, never committed
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ram_wr_r <= '0;
            wr_addr_r <= pms_pkg::PMS_RAM_ADDR_RST;
            cfg_loaded_r <= 1'b0;
        end else begin
            ram_wr_r.write <= 1'b0;
            // RULE11: bytes after the first go to the mode handler
            if (state_r == pms_pkg::PMS_ST_CFG && rx_ok) begin
                ram_wr_r.write <= 1'b1;
                ram_wr_r.addr <= wr_addr_r;
                ram_wr_r.data <= uart_rx.data;
                // wraps at the top; a fresh download simply overwrites
                wr_addr_r <= wr_addr_r + 6'h01;
                cfg_loaded_r <= 1'b1;
            end
        end
    end

    // RULE6: RAM contents cleared on each reset
    pms_cfg_ram u_ram (
        .clk(clk),
        .nrst(nrst),
        .wr(ram_wr_r),
        .rd_addr(cfg_rd_addr),
        .rd_data(cfg_rd_data)
    );

    // ============================================================
    // direct test traffic routing
    // the same serial pins carry test bytes in both directions
    // RULE9: received bytes forwarded
    // RULE8: no test path with stored settings
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dtm_rx <= '0;
        end else begin
            dtm_rx.valid <= test_path(state_r) && rx_ok;
            dtm_rx.data <= uart_rx.data;
        end
    end

    // RULE9: test replies sent back
    // replies offered outside test mode are dropped, not held: there
    // is no buffer, so the handler must only talk once the mode is set
    always_ff @(posedge clk) begin
        if (!nrst) begin
            uart_tx <= '0;
        end else begin
            uart_tx.valid <= test_path(state_r) && dtm_tx.valid;
            uart_tx.data <= dtm_tx.data;
        end
    end

    // ============================================================
    // status outputs
    // every flag but cfg_loaded registers state_nxt, so it changes on the very edge
    // at which the selector leaves the check or takes the first byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode <= pms_pkg::PMS_MODE_NONE;
        end else begin
            mode <= mode_of(state_nxt);
        end
    end

    // RULE2: stored settings loaded
    always_ff @(posedge clk) begin
        if (!nrst) begin
            load_otp <= 1'b0;
        end else begin
            load_otp <= state_nxt == pms_pkg::PMS_ST_NORMAL;
        end
    end

    // RULE7: port closed when stored
    // the port also stays shut during the check, so noise on the
    // receive pin before the decision cannot pick a mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            uart_enable <= 1'b0;
        end else begin
            uart_enable <= port_open(state_nxt);
        end
    end

    // RULE10: power saving only normal
    // test and download keep the chip fully awake; a bench supply or
    // a spare battery is expected during those sessions
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwr_mgmt_enable <= 1'b0;
        end else begin
            pwr_mgmt_enable <= state_nxt == pms_pkg::PMS_ST_NORMAL;
        end
    end

    assign cfg_loaded = cfg_loaded_r;
    assign cfg_count = wr_addr_r;

endmodule : pms_mode_select
`default_nettype wire

// ===== testbench/pms_host_model.sv
// host tool model: hands whole received bytes to the mode selector
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
    input wire logic clk,
    output pms_pkg::pms_byte_t rx
);
    initial rx = '0;
    // sends back to back; call 1ns after a rising edge
    // host sends the first n bytes of b
    task automatic send(input logic [7:0] b [4], input int n);
        for (int i = 0; i < n; i++) begin
            rx <= {1'b1, b[i]};
            @(posedge clk);
            #1;
        end
        // released data shows the inverse so a stale byte never matches
        rx <= {1'b0, ~b[n-1]};
    endtask : send
endmodule : pms_host_model
`default_nettype wire

// ===== testbench/pms_mode_select_monitor.sv
// checker of the mode selector port behaviour
`timescale 1ns/1ps
`default_nettype none
module pms_mode_select_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire pms_pkg::pms_byte_t uart_rx,
    input wire pms_pkg::pms_byte_t dtm_rx,
    input wire pms_pkg::pms_mode_t mode,
    input wire logic load_otp,
    input wire logic uart_enable,
    input wire logic pwr_mgmt_enable,
    input wire logic [pms_pkg::PMS_RAM_AW-1:0] cfg_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // a byte taken while no mode is chosen yet
    logic first_w;
    assign first_w = (mode == pms_pkg::PMS_MODE_NONE) && uart_enable
        && uart_rx.valid;
    otp_start_a: assert property (
        $rose(load_otp) |-> mode == pms_pkg::PMS_MODE_NORMAL
        && pwr_mgmt_enable) else $error("stored start wrong");
    uart_off_a: assert property (
        load_otp |-> !uart_enable) else $error("serial on with stored cfg");
    otp_hold_a: assert property (
        load_otp |=> load_otp && mode == pms_pkg::PMS_MODE_NORMAL)
        else $error("left normal operation");
    cfg_sel_a: assert property (
        first_w && uart_rx.data == pms_pkg::PMS_CFG_REQ_BYTE
        |=> mode == pms_pkg::PMS_MODE_CFG) else $error("no download");
    dtm_sel_a: assert property (
        first_w && uart_rx.data != pms_pkg::PMS_CFG_REQ_BYTE
        |=> mode == pms_pkg::PMS_MODE_DTM) else $error("no test mode");
    pwr_off_a: assert property (
        mode inside {pms_pkg::PMS_MODE_CFG, pms_pkg::PMS_MODE_DTM}
        |-> !pwr_mgmt_enable) else $error("power management on");
    only_dtm_a: assert property (
        dtm_rx.valid |-> mode == pms_pkg::PMS_MODE_DTM)
        else $error("forward outside test mode");
    first_drop_a: assert property (
        first_w |=> !dtm_rx.valid) else $error("first byte forwarded");
    cnt_inc_a: assert property (
        mode == pms_pkg::PMS_MODE_CFG && uart_rx.valid
        |=> cfg_count == 6'($past(cfg_count) + 1'b1))
        else $error("download count wrong");
endmodule : pms_mode_select_monitor
bind pms_mode_select pms_mode_select_monitor pms_mode_select_monitor_i (
    .clk, .nrst, .uart_rx, .dtm_rx, .mode, .load_otp, .uart_enable,
    .pwr_mgmt_enable, .cfg_count);
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench of the power-up mode selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    n_fail++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic otp_valid = 1'b0;
    pms_pkg::pms_byte_t uart_rx, dtm_rx, uart_tx;
    pms_pkg::pms_byte_t dtm_tx = '0;
    logic [pms_pkg::PMS_RAM_AW-1:0] rd_addr = '0;
    logic [pms_pkg::PMS_RAM_AW-1:0] cnt;
    logic [7:0] rd_data, rx_last, d;
    logic [7:0] tx_last = 8'h00_00;
    pms_pkg::pms_mode_t mode;
    logic load_otp, uart_en, pwr, loaded;
    int rx_n = 0;
    int n_fail = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    pms_host_model pms_host_model_i (.clk(clk), .rx(uart_rx));
    pms_mode_select pms_mode_select_i (.clk(clk), .nrst(nrst),
        .otp_valid(otp_valid), .uart_rx(uart_rx), .dtm_tx(dtm_tx),
        .cfg_rd_addr(rd_addr), .cfg_rd_data(rd_data), .dtm_rx(dtm_rx),
        .uart_tx(uart_tx), .mode(mode), .load_otp(load_otp),
        .uart_enable(uart_en), .pwr_mgmt_enable(pwr),
        .cfg_loaded(loaded), .cfg_count(cnt));
    // record forwarded bytes; the pulses last one cycle only
    always @(posedge clk) begin
        if (dtm_rx.valid) begin
            rx_last <= dtm_rx.data;
            rx_n <= rx_n + 1;
        end
        if (uart_tx.valid) tx_last <= uart_tx.data;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // reset, then flip the stored flag: later changes must be ignored
    task automatic restart(input logic otp, input int len);
        nrst = 1'b0;
        otp_valid = otp;
        tick(len);
        `CHK("mode in reset", pms_pkg::PMS_MODE_NONE, mode)
        nrst = 1'b1;
        tick(5);
        otp_valid = ~otp;
    endtask : restart
    task automatic read_ram(input logic [pms_pkg::PMS_RAM_AW-1:0] a);
        rd_addr = a;
        tick(2);
        d = rd_data;
    endtask : read_ram
    task automatic t_otp();
        restart(1'b1, 12);
        `CHK("mode", pms_pkg::PMS_MODE_NORMAL, mode)
        `CHK("load_otp", 1'b1, load_otp)
        `CHK("uart_enable", 1'b0, uart_en)
        pms_host_model_i.send('{8'h00, 8'h00, 8'h00, 8'h00}, 1);
        tick(2);
        `CHK("mode kept", pms_pkg::PMS_MODE_NORMAL, mode)
        $display("test stored config done");
    endtask : t_otp
    task automatic t_cfg();
        restart(1'b0, 2);
        `CHK("mode idle", pms_pkg::PMS_MODE_NONE, mode)
        `CHK("uart_enable", 1'b1, uart_en)
        pms_host_model_i.send('{8'hff, 8'h12, 8'h34, 8'hff}, 4);
        tick(2);
        `CHK("mode", pms_pkg::PMS_MODE_CFG, mode)
        `CHK("pwr", 1'b0, pwr)
        `CHK("count", 6'h00_03, cnt)
        `CHK("loaded", 1'b1, loaded)
        `CHK("not forwarded", 0, rx_n)
        read_ram(6'h00_00);
        `CHK("ram 0", 8'h00_12, d)
        read_ram(6'h00_02);
        `CHK("ram 2", 8'h00_ff, d)
        restart(1'b0, 2);
        `CHK("count cleared", 6'h00_00, cnt)
        `CHK("loaded cleared", 1'b0, loaded)
        read_ram(6'h00_00);
        `CHK("ram cleared", 8'h00_00, d)
        $display("test download done");
    endtask : t_cfg
    task automatic t_dtm();
        pms_host_model_i.send('{8'ha5, 8'h00, 8'h00, 8'h00}, 1);
        tick(2);
        `CHK("mode", pms_pkg::PMS_MODE_DTM, mode)
        `CHK("pwr", 1'b0, pwr)
        `CHK("first dropped", 0, rx_n)
        pms_host_model_i.send('{8'hff, 8'h00, 8'h00, 8'h00}, 1);
        dtm_tx = {1'b1, 8'h00_3c};
        tick(1);
        dtm_tx = '0;
        tick(3);
        `CHK("rx count", 1, rx_n)
        `CHK("rx byte", 8'h00_ff, rx_last)
        `CHK("tx byte", 8'h00_3c, tx_last)
        `CHK("mode kept", pms_pkg::PMS_MODE_DTM, mode)
        $display("test direct test done");
    endtask : t_dtm
    task automatic finish_test();
        $display("%0d compared, %0d failed", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // watchdog: the tests need well under 200 cycles
    initial begin
        #100000;
        n_fail++;
        $display("[FAIL] watchdog expired");
        finish_test();
    end
    initial begin
        t_otp();
        t_cfg();
        t_dtm();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
